// ### core/ebi_map.vh
// constants for the external bus interface block
`ifndef EBI_MAP_VH
`define EBI_MAP_VH
// processor modes
`define EBI_MODE_SINGLE 2'h0
`define EBI_MODE_EXPAND 2'h1
`define EBI_MODE_MICRO 2'h3
// bus multiplex select codes
`define EBI_MUX_NONE 2'h0
`define EBI_MUX_AREA2 2'h1
`define EBI_MUX_AREA1 2'h2
`define EBI_MUX_ALL 2'h3
// access kinds
`define EBI_KIND_SFR 3'h0
`define EBI_KIND_RAM 3'h1
`define EBI_KIND_ROM 3'h2
`define EBI_KIND_FLASH 3'h3
`define EBI_KIND_EXT 3'h4
// address width masks
`define EBI_AMASK_12 20'h00FFF
`define EBI_AMASK_16 20'h0FFFF
`define EBI_AMASK_20 20'hFFFFF
// area numbers
`define EBI_AREA1 2'h1
`define EBI_AREA2 2'h2
// bus clock divider default: one link cycle per four system cycles
`define EBI_BCLK_DIV 4
`endif

// ### core/ebi_sync.v
// two flip-flop synchroniser for signals from outside the clock domain
`timescale 1ns/1ps
module ebi_sync #(
	parameter WIDTH = 1,
	parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
	clk, // system clock
	rst, // asynchronous reset
	d, // asynchronous input
	q // synchronised output
);
	input wire clk;
	input wire rst;
	input wire [WIDTH-1:0] d;
	output reg [WIDTH-1:0] q;
	reg [WIDTH-1:0] meta;
	// first stage is read only by the second
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			meta <= INIT;
			q <= INIT;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule // ebi_sync

// ### core/ebi_core.v
// external bus interface: wait states, multiplexed bus and strobes
`timescale 1ns/1ps
`include "ebi_map.vh"
// Operation
// - ram/rom one cycle, slow bit two; sfr two
// - data flash slow if either slow bit
// - bus pins only in expansion modes
// - multiplex select field picks addressing
// - decode 00 none, 01 area2, 10 area1, 11 all
// - 8-bit mux: d0-7 share a0-7
// - 16-bit mux: d0-7 share a1-8
// - multiplexed area reached by even addresses
// - address width from two select bits
// - address undefined until first external access
// - width pin high 8 lines, low 16
// - each area select enabled by own bit
// - four regions each with own select
// - new region: address and select change
// - same region: address changes, select held
// - internal access: select off, address held
// - idle: address and select held
// - two strobe schemes on 16-bit bus
// - scheme bit 0 ube, 1 split; 8-bit forces 0
// - split scheme: low/high/both write strobes
// - ube scheme: enable plus a0 give size
// - 8-bit bus: read and store only
// - wait input low at last fall adds wait
// - outputs frozen during ready waits
// - wait input high finishes the cycle
// - wait input honoured only with area wait flag 0
module ebi_core #(
	parameter DIV = `EBI_BCLK_DIV // system cycles per bus clock, even
) (
	clk, // system clock
	rst, // asynchronous reset, active high
	proc_mode, // processor mode bits
	bus_multiplex_select, // multiplexed area selection
	upper_address_port_select, // a16-a19 as ports when 1
	mid_address_port_select, // a12-a15 as ports when 1
	strobe_scheme_select, // 0 ube scheme, 1 split stores
	global_slow_access, // global slow access bit
	flash_data_slow_access, // data flash slow access bit
	area_pin_enable, // per-area select pin enables
	area_wait_flag, // per-area wait flag, 0 = waits allowed
	req_valid, // access request
	req_kind, // access kind
	req_write, // 1 write, 0 read
	req_word, // 1 word, 0 byte
	req_addr, // byte address
	req_area, // external area number
	req_wdata, // write data
	req_ready, // request accepted
	done, // access finished pulse
	rdata, // read data
	byte_pin, // width select pin, high = 8 bits
	ready_wait_n, // slow-device wait input
	data_in, // data bus input
	bclk, // bus clock output
	addr_out, // address pins
	addr_oe, // address pin enables
	data_out, // data pin outputs
	data_oe, // data pin enables
	area_select_n, // area select pins
	area_oe, // area select pin enables
	read_n, // read strobe
	store_low_byte_n, // store or store-low strobe
	store_high_byte_n, // store-high strobe or upper byte enable
	addr_latch, // address latch pulse
	bus_pins_on, // bus control pins active
	hold_acknowledge_n // hold acknowledge, never asserted here
);
	input wire clk;
	input wire rst;
	input wire [1:0] proc_mode;
	input wire [1:0] bus_multiplex_select;
	input wire upper_address_port_select;
	input wire mid_address_port_select;
	input wire strobe_scheme_select;
	input wire global_slow_access;
	input wire flash_data_slow_access;
	input wire [3:0] area_pin_enable;
	input wire [3:0] area_wait_flag;
	input wire req_valid;
	input wire [2:0] req_kind;
	input wire req_write;
	input wire req_word;
	input wire [19:0] req_addr;
	input wire [1:0] req_area;
	input wire [15:0] req_wdata;
	output reg req_ready;
	output reg done;
	output reg [15:0] rdata;
	input wire byte_pin;
	input wire ready_wait_n;
	input wire [15:0] data_in;
	output reg bclk;
	output reg [19:0] addr_out;
	output reg [19:0] addr_oe;
	output reg [15:0] data_out;
	output reg [15:0] data_oe;
	output reg [3:0] area_select_n;
	output reg [3:0] area_oe;
	output reg read_n;
	output reg store_low_byte_n;
	output reg store_high_byte_n;
	output reg addr_latch;
	output reg bus_pins_on;
	output reg hold_acknowledge_n;

	// ==========================================================
	// pin synchronisers and bus clock enables
	wire byte_s;
	wire rdy_s;
	wire [15:0] din_s;
	ebi_sync #(.WIDTH(18), .INIT(18'h30000)) u_sync (
		.clk(clk),
		.rst(rst),
		.d({byte_pin, ready_wait_n, data_in}),
		.q({byte_s, rdy_s, din_s})
	);
	localparam HALF = DIV / 2;
	reg [7:0] div_cnt;
	wire rise_en = (div_cnt == 8'h00);
	wire fall_en = (div_cnt == HALF[7:0]);
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			div_cnt <= 8'h00;
			bclk <= 1'b0;
		end else begin
			div_cnt <= (div_cnt == DIV[7:0] - 8'h01) ? 8'h00 :
				div_cnt + 8'h01;
			if (rise_en)
				bclk <= 1'b1;
			else if (fall_en)
				bclk <= 1'b0;
		end
	end

	// ==========================================================
	// configuration decode
	wire ext_mode = (proc_mode == `EBI_MODE_EXPAND) ||
		(proc_mode == `EBI_MODE_MICRO);
	wire bus8 = byte_s;
	wire split = strobe_scheme_select & ~bus8;
	reg [19:0] amask;
	always @* begin
		// the illegal combination falls back to 12 bits
		if (mid_address_port_select)
			amask = `EBI_AMASK_12;
		else if (upper_address_port_select)
			amask = `EBI_AMASK_16;
		else
			amask = `EBI_AMASK_20;
	end
	function is_mux;
		input [1:0] sel;
		input [1:0] area;
		begin
			case (sel)
			`EBI_MUX_NONE: is_mux = 1'b0;
			`EBI_MUX_AREA2: is_mux = (area == `EBI_AREA2);
			`EBI_MUX_AREA1: is_mux = (area == `EBI_AREA1);
			default: is_mux = 1'b1;
			endcase
		end
	endfunction
	// internal cycles in bus clocks
	reg [1:0] int_len;
	always @* begin
		case (req_kind)
		`EBI_KIND_SFR: int_len = 2'h2;
		`EBI_KIND_FLASH: int_len = (global_slow_access |
			flash_data_slow_access) ? 2'h2 : 2'h1;
		default: int_len = global_slow_access ? 2'h2 : 2'h1;
		endcase
	end

	// ==========================================================
	// bus state machine, advancing on bus clock rising edges
	localparam ST_IDLE = 3'h0;
	localparam ST_INT = 3'h1;
	localparam ST_ADDR = 3'h2;
	localparam ST_STRB = 3'h3;
	localparam ST_WAIT = 3'h4;
	localparam ST_END = 3'h5;
	reg [2:0] state;
	reg [1:0] cnt;
	reg cur_mux;
	reg cur_write;
	reg cur_word;
	reg [1:0] cur_area;
	reg [19:0] cur_addr;
	reg [15:0] cur_wdata;
	// the wait input reaches the logic two system clocks late through the
	// synchroniser, so at a bus clock rise it shows the pin as it stood at
	// the preceding fall (exact for DIV of 4, later in the low phase above)
	wire rdy_low = ~rdy_s & ~area_wait_flag[cur_area];
	reg [19:0] ea;
	always @* begin
		ea = req_addr & amask;
		// multiplexed areas are only reached at even addresses
		if (is_mux(bus_multiplex_select, req_area))
			ea[0] = 1'b0;
	end
	wire take = req_valid & req_ready & rise_en;
	wire ext_req = (req_kind == `EBI_KIND_EXT) & ext_mode;

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= ST_IDLE;
			cnt <= 2'h0;
			cur_mux <= 1'b0;
			cur_write <= 1'b0;
			cur_word <= 1'b0;
			cur_area <= 2'h0;
			cur_addr <= 20'h00000;
			cur_wdata <= 16'h0000;
			req_ready <= 1'b0;
			done <= 1'b0;
			rdata <= 16'h0000;
			addr_out <= 20'h00000;
			addr_oe <= 20'h00000;
			data_out <= 16'h0000;
			data_oe <= 16'h0000;
			area_select_n <= 4'hF;
			area_oe <= 4'h0;
			read_n <= 1'b1;
			store_low_byte_n <= 1'b1;
			store_high_byte_n <= 1'b1;
			addr_latch <= 1'b0;
			bus_pins_on <= 1'b0;
			hold_acknowledge_n <= 1'b1;
		end else begin
			done <= 1'b0;
			bus_pins_on <= ext_mode;
			area_oe <= ext_mode ? area_pin_enable : 4'h0;
			// pins stay off until an external access drives them
			if (!ext_mode)
				addr_oe <= 20'h00000;
			else
				addr_oe <= addr_oe & amask; // narrowing frees pins at once
			if (!ext_mode)
				data_oe <= 16'h0000;
			if (rise_en) begin
				case (state)
				ST_IDLE: begin
					req_ready <= 1'b1;
					// in split scheme the high strobe idles high
					// even where the ube scheme left it low
					if (split)
						store_high_byte_n <= 1'b1;
					if (take && ext_req) begin
						req_ready <= 1'b0;
						cur_mux <= is_mux(bus_multiplex_select,
							req_area);
						cur_write <= req_write;
						cur_word <= req_word & ~bus8;
						cur_area <= req_area;
						cur_addr <= ea;
						cur_wdata <= req_wdata;
						addr_out <= ea;
						addr_oe <= amask;
						area_select_n <= ~(4'h1 << req_area);
						if (is_mux(bus_multiplex_select, req_area))
							addr_latch <= 1'b1;
						if (is_mux(bus_multiplex_select, req_area)) begin
							data_out <= bus8 ? {8'h00, ea[7:0]} :
								{8'h00, ea[8:1]};
							data_oe <= 16'h00FF;
						end else
							data_oe <= 16'h0000;
						// ube and a0 tell the size
						if (!split)
							store_high_byte_n <= bus8 |
								~(req_word | ea[0]);
						state <= ST_ADDR;
					end else if (take) begin
						req_ready <= 1'b0;
						area_select_n <= 4'hF;
						cnt <= int_len;
						state <= ST_INT;
					end
				end
				ST_INT: begin
					if (cnt == 2'h1) begin
						done <= 1'b1;
						req_ready <= 1'b1;
						state <= ST_IDLE;
					end
					cnt <= cnt - 2'h1;
				end
				ST_ADDR: begin
					// latch pulse falls, shared lines to data
					addr_latch <= 1'b0;
					if (cur_write) begin
						data_out <= cur_wdata;
						// upper lines unused for multiplexed area
						data_oe <= (bus8 | cur_mux) ? 16'h00FF :
							16'hFFFF;
					end else
						data_oe <= 16'h0000;
					if (!cur_write)
						read_n <= 1'b0;
					else if (split) begin
						// low byte on even, high on odd or word
						store_low_byte_n <= ~(cur_word | ~cur_addr[0]);
						store_high_byte_n <= ~(cur_word | cur_addr[0]);
					end else
						store_low_byte_n <= 1'b0;
					state <= ST_STRB;
				end
				ST_STRB, ST_WAIT: begin
					if (rdy_low)
						state <= ST_WAIT;
					else
						state <= ST_END;
				end
				ST_END: begin
					if (!cur_write)
						rdata <= din_s;
					read_n <= 1'b1;
					store_low_byte_n <= 1'b1;
					// ube keeps its level until the next external access
					if (split)
						store_high_byte_n <= 1'b1;
					data_oe <= 16'h0000;
					done <= 1'b1;
					req_ready <= 1'b1;
					state <= ST_IDLE;
				end
				default: state <= ST_IDLE;
				endcase
			end
		end
	end
endmodule // ebi_core

// ### verif/ebi_core_properties.sv
// assertion checker for the external bus interface
`timescale 1ns/1ps
module ebi_core_chk #(parameter DIV = 4) (
	input wire clk, // clock
	input wire rst, // reset
	input wire [1:0] proc_mode, // mode
	input wire mid_address_port_select, // 12-bit select
	input wire [3:0] area_pin_enable, // pin enables
	input wire [19:0] addr_out, // address
	input wire [19:0] addr_oe, // address enables
	input wire [3:0] area_select_n, // selects
	input wire [3:0] area_oe, // select enables
	input wire read_n, // read strobe
	input wire store_low_byte_n, // store strobe
	input wire addr_latch, // latch pulse
	input wire hold_acknowledge_n // hold ack
);
	// ==================================================
	// properties
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_single_no_pins: assert property (
		(proc_mode == 2'h0) [*3] |-> area_oe == 4'h0 && addr_oe == 20'h00000)
		else $error("pins driven in single-chip mode");
	a_pin_enable_gate: assert property (
		$stable(area_pin_enable) [*3] |-> (area_oe & ~area_pin_enable) == 4'h0)
		else $error("select driven without its enable");
	a_strobe_excl: assert property (
		!(!read_n && !store_low_byte_n))
		else $error("read and store low together");
	a_strobe_freeze: assert property (
		!read_n && $past(!read_n) |-> $stable(addr_out) && $stable(area_select_n))
		else $error("address or select moved under strobe");
	a_ale_before_data: assert property (
		addr_latch |-> read_n && store_low_byte_n)
		else $error("strobe during latch pulse");
	a_width_twelve: assert property (
		mid_address_port_select [*3] |-> addr_oe[19:12] == 8'h00)
		else $error("upper address pins on in 12-bit mode");
	a_read_ends: assert property (
		$fell(read_n) |-> ##[1:400] $rose(read_n))
		else $error("read strobe never released");
	a_hold_idle: assert property (
		hold_acknowledge_n)
		else $error("hold acknowledge asserted");
endmodule // ebi_core_chk

bind ebi_core ebi_core_chk #(.DIV(DIV)) chk_u (.clk, .rst, .proc_mode,
	.mid_address_port_select, .area_pin_enable, .addr_out, .addr_oe,
	.area_select_n, .area_oe, .read_n, .store_low_byte_n, .addr_latch,
	.hold_acknowledge_n);

// ### verif/ebi_ext_mem.sv
// behavioural external memory on the parallel bus
`timescale 1ns/1ps
module ebi_ext_mem (
	input wire bclk, // bus clock
	input wire [19:0] addr_out, // address pins
	input wire [15:0] data_out, // data pins, shared lines when multiplexed
	input wire read_n, // read strobe
	input wire addr_latch, // latch pulse
	input wire [3:0] stall, // waits to demand per read
	output logic [15:0] data_in, // data towards the block
	output logic ready_wait_n, // wait line, pulled high
	output logic [19:0] lat_addr // address caught by the latch
);
	// ==================================================
	// model
	localparam [15:0] DPAT = 16'h5AC3;
	logic [3:0] left = 4'h0;
	initial lat_addr = 20'h00000;
	// low address byte is taken from the shared data lines
	always @(negedge addr_latch)
		lat_addr <= {addr_out[19:8], data_out[7:0]};
	always @(negedge bclk) begin
		if (read_n) left <= stall;
		else if (left != 4'h0) left <= left - 4'h1;
	end
	// pull-up keeps the wait line high outside a slow read
	assign ready_wait_n = read_n || left == 4'h0;
	// a released bus must not look like valid data
	assign data_in = read_n ? ~DPAT : DPAT;
endmodule // ebi_ext_mem

// ### verif/ebi_core_test.sv
// self-checking testbench for the external bus interface
`timescale 1ns/1ps
module ebi_core_test;
	localparam int DIV = 4;
	logic clk = 0, rst = 1, upper_address_port_select = 0, req_valid = 0;
	logic mid_address_port_select = 0, strobe_scheme_select = 0, req_word = 0;
	logic global_slow_access = 0, flash_data_slow_access = 0, req_write = 0;
	logic byte_pin = 0;
	logic [1:0] proc_mode = 2'h0, bus_multiplex_select = 2'h0, req_area = 2'h0;
	logic [3:0] area_pin_enable = 4'hF, area_wait_flag = 4'h0, stall = 4'h0;
	logic [2:0] req_kind = 3'h0, lo;
	logic [19:0] req_addr = 20'h00000;
	logic [15:0] req_wdata = 16'h1234;
	logic [4:0] cs;
	wire req_ready, done, bclk, read_n, store_low_byte_n, store_high_byte_n;
	wire addr_latch, ready_wait_n, bus_pins_on;
	wire [15:0] rdata, data_in, data_out;
	wire [19:0] addr_out, addr_oe, lat_addr;
	wire [3:0] area_select_n, area_oe;
	int n_mismatch = 0, n_checks = 0, cyc;
	ebi_core #(.DIV(DIV)) dut_u (.clk, .rst, .proc_mode, .bus_multiplex_select,
		.upper_address_port_select, .mid_address_port_select,
		.strobe_scheme_select, .global_slow_access, .flash_data_slow_access,
		.area_pin_enable, .area_wait_flag, .req_valid, .req_kind, .req_write,
		.req_word, .req_addr, .req_area, .req_wdata, .req_ready, .done, .rdata,
		.byte_pin, .ready_wait_n, .data_in, .bclk, .addr_out, .addr_oe,
		.data_out, .data_oe(), .area_select_n, .area_oe, .read_n,
		.store_low_byte_n, .store_high_byte_n, .addr_latch, .bus_pins_on,
		.hold_acknowledge_n());
	ebi_ext_mem mem_u (.bclk, .addr_out, .data_out, .read_n, .addr_latch,
		.stall, .data_in, .ready_wait_n, .lat_addr);
	// ==================================================
	// helpers
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// offer at a bus clock rise, gather strobes and selects until done
	task automatic acc(input logic [2:0] k, input logic w, input logic wd,
			input logic [19:0] a, input logic [1:0] ar);
		logic r, b;
		int i;
		{req_kind, req_write, req_word, req_addr, req_area} = {k, w, wd, a, ar};
		req_valid = 1;
		for (i = 0; i < 200; i++) begin
			r = req_ready;
			b = bclk;
			@(posedge clk);
			#1;
			if (r && !b && bclk) break;
		end
		req_valid = 0;
		{lo, cs, cyc} = '0;
		while (done !== 1'b1 && cyc < 400) begin
			lo |= {~read_n, ~store_low_byte_n, ~store_high_byte_n};
			cs |= {addr_latch, ~area_select_n};
			@(posedge clk);
			#1;
			cyc++;
		end
		if (cyc >= 400 || i >= 200) begin
			n_mismatch++;
			results;
		end
	endtask
	// ==================================================
	// scenarios
	task automatic t_internal;
		for (int n = 0; n < 16; n++) begin
			{global_slow_access, flash_data_slow_access} = n[3:2];
			acc(n[2:0] & 3'h3, 0, 1, 20'h00400, 2'h0);
			chk(cyc, DIV * (n[1:0] == 0 ? 2 : 1 + (n[3] | (n[1:0] == 3 & n[2]))));
		end
		{global_slow_access, flash_data_slow_access} = 2'b00;
		acc(3'h4, 0, 1, 20'h08000, 2'h1);
		chk({lo, cs}, 8'h00);
		chk({bus_pins_on, area_oe}, 5'h00);
	endtask
	task automatic t_ext;
		proc_mode = 2'h1;
		repeat (4) @(posedge clk);
		#1;
		chk({bus_pins_on, area_oe}, 5'h1F);
		acc(3'h4, 0, 1, 20'h08010, 2'h0);
		chk(rdata, 16'h5AC3);
		chk({lo, cs}, 8'b101_00001);
		chk(cyc, 3 * DIV);
		chk(addr_oe, 20'hFFFFF);
		repeat (8) @(posedge clk);
		#1;
		chk({area_select_n, addr_out}, {4'hE, 20'h08010});
		acc(3'h4, 0, 1, 20'h08020, 2'h2);
		chk({lo, cs}, 8'b101_00100);
		acc(3'h1, 0, 1, 20'h00400, 2'h0);
		chk({area_select_n, addr_out}, {4'hF, 20'h08020});
	endtask
	task automatic t_strobes;
		logic [6:0] tb [7] = '{7'b0100010, 7'b0101001, 7'b0110011, 7'b0000010,
			7'b0001011, 7'b0010011, 7'b1101010};
		foreach (tb[i]) begin
			{byte_pin, strobe_scheme_select} = tb[i][6:5];
			acc(3'h4, 1, tb[i][4], {19'h04000, tb[i][3]}, 2'h0);
			chk(lo & (tb[i][6] ? 3'b110 : 3'b111), tb[i][2:0]);
		end
	endtask
	task automatic t_mux;
		byte_pin = 1;
		for (int i = 0; i < 8; i++) begin
			bus_multiplex_select = i[2:1];
			acc(3'h4, 0, 0, 20'h00033, i[0] ? 2'h2 : 2'h1);
			chk(cs[4], i[0] ? i[1] : i[2]);
			if (cs[4]) chk(lat_addr[7:0], 8'h32);
		end
		{byte_pin, bus_multiplex_select} = 3'b011;
		acc(3'h4, 0, 1, 20'h00067, 2'h1);
		chk({cs[4], lat_addr[7:0], addr_out[0]}, 10'h266);
		{byte_pin, bus_multiplex_select, upper_address_port_select} = 4'h1;
		acc(3'h4, 0, 1, 20'h08050, 2'h0);
		chk(addr_oe[19:12], 8'h0F);
		mid_address_port_select = 1;
		acc(3'h4, 0, 1, 20'h08060, 2'h0);
		chk(addr_oe[19:12], 8'h00);
	endtask
	task automatic t_rdy;
		int base;
		acc(3'h4, 0, 1, 20'h00070, 2'h3);
		base = cyc;
		stall = 4'h3;
		acc(3'h4, 0, 1, 20'h00072, 2'h3);
		chk(cyc, base + 3 * DIV);
		area_wait_flag = 4'h8;
		acc(3'h4, 0, 1, 20'h00074, 2'h3);
		chk(cyc, base);
		area_pin_enable = 4'h5;
		repeat (2) @(posedge clk);
		#1;
		chk(area_oe, 4'h5);
	endtask
	// ==================================================
	// run
	initial begin
		forever #2.5 clk = ~clk;
	end
	initial begin
		repeat (2) @(posedge clk);
		#1;
		rst = 0;
		t_internal;
		t_ext;
		t_strobes;
		t_mux;
		t_rdy;
		results;
	end
endmodule // ebi_core_test
